// File: rtl/bkb_pkg.sv
// Purpose: shared constants of the channel B data and bus-cycle comparator
// Assumes: 8-bit register address, 32-bit register data
// Notes: offsets are byte addresses of aligned words
package bkb_pkg;
	// ==========================================================
	// register offsets
	localparam logic [7:0] OFF_VALUE = 8'h00;
	localparam logic [7:0] OFF_MASK = 8'h04;
	localparam logic [7:0] OFF_CYCSEL = 8'h08;
	localparam logic [7:0] OFF_CTRL = 8'h0c;
	localparam logic [7:0] OFF_CAPTURE = 8'h10;
	localparam logic [7:0] OFF_COUNT = 8'h14;
	// ==========================================================
	// reset values
	localparam logic [31:0] RST_VALUE = 32'h0000_0000;
	localparam logic [31:0] RST_MASK = 32'h0000_0000;
	localparam logic [15:0] RST_CYCSEL = 16'h0000;
	localparam logic [31:0] RST_CAPTURE = 32'h0000_0000;
	localparam logic [15:0] RST_COUNT = 16'h0000;
	localparam logic [31:0] RD_IDLE = 32'h0000_0000;
	// ==========================================================
	// field positions
	localparam int CYCSEL_W = 16;
	localparam int CYCSEL_USED_W = 8;
	localparam int SRC_LSB = 6;
	localparam int KIND_LSB = 4;
	localparam int DIR_LSB = 2;
	localparam int SIZE_LSB = 0;
	localparam int CTRL_CPU_FLAG_BIT = 14;
	localparam int CTRL_DMA_FLAG_BIT = 12;
	localparam int CTRL_DATA_EN_BIT = 7;
	// ==========================================================
	// two-bit field encodings and match counter limit
	localparam logic [1:0] SEL_OFF = 2'h0;
	localparam logic [1:0] SEL_LO = 2'h1;
	localparam logic [1:0] SEL_HI = 2'h2;
	localparam logic [1:0] SEL_BOTH = 2'h3;
	localparam logic [1:0] SIZE_BYTE = 2'h1;
	localparam logic [1:0] SIZE_WORD = 2'h2;
	localparam logic [1:0] SIZE_LONG = 2'h3;
	localparam logic [15:0] COUNT_MAX = 16'hffff;
endpackage

// File: rtl/bkb_data_cmp.sv
// Purpose: masked per-bit data comparison
// Assumes: all inputs on the core clock, purely combinational
// Notes: a set mask bit removes that bit from the comparison
`timescale 1ns/1ps
`default_nettype none
module bkb_data_cmp #(
	parameter int WIDTH = 32
) (
	// operands
	input wire logic [WIDTH-1:0] data_in,
	input wire logic [WIDTH-1:0] value_in,
	input wire logic [WIDTH-1:0] mask_in,
	// result
	output logic hit_out
);
	// ==========================================================
	// per-bit compare
	logic [WIDTH-1:0] bit_ok;
	genvar n;
	generate
		for (n = 0; n < WIDTH; n++)
		begin : g_bit
			assign bit_ok[n] = mask_in[n] | ~(data_in[n] ^ value_in[n]); // RULE3
		end
	endgenerate
	assign hit_out = &bit_ok; // RULE14
endmodule
`default_nettype wire

// File: rtl/bkb_cycle_cmp.sv
// Purpose: bus-cycle attribute comparison against the cycle selector
// Assumes: one bus cycle per valid clock, combinational
// Notes: a field of zero leaves that attribute out of the condition
`timescale 1ns/1ps
`default_nettype none
module bkb_cycle_cmp (
	// selector fields
	input wire logic [1:0] src_sel_in,
	input wire logic [1:0] kind_sel_in,
	input wire logic [1:0] dir_sel_in,
	input wire logic [1:0] size_sel_in,
	// bus cycle attributes
	input wire logic is_dma_in,
	input wire logic is_fetch_in,
	input wire logic is_write_in,
	input wire logic [1:0] size_in,
	// result
	output logic hit_out
);
	logic src_ok;
	logic kind_ok;
	logic dir_ok;
	logic size_ok;
	// ==========================================================
	// field checks
	always_comb
	begin
		src_ok = (src_sel_in == bkb_pkg::SEL_OFF) || (src_sel_in[0] && !is_dma_in)
			|| ((src_sel_in == bkb_pkg::SEL_HI) && is_dma_in); // RULE8
		kind_ok = (kind_sel_in == bkb_pkg::SEL_OFF) || (kind_sel_in == bkb_pkg::SEL_BOTH)
			|| ((kind_sel_in == bkb_pkg::SEL_LO) && is_fetch_in)
			|| ((kind_sel_in == bkb_pkg::SEL_HI) && !is_fetch_in); // RULE9
		dir_ok = (dir_sel_in == bkb_pkg::SEL_OFF) || (dir_sel_in == bkb_pkg::SEL_BOTH)
			|| ((dir_sel_in == bkb_pkg::SEL_LO) && !is_write_in)
			|| ((dir_sel_in == bkb_pkg::SEL_HI) && is_write_in); // RULE10
		size_ok = (size_sel_in == bkb_pkg::SEL_OFF) || (size_sel_in == size_in); // RULE11
	end
	assign hit_out = src_ok && kind_ok && dir_ok && size_ok; // RULE14
endmodule
`default_nettype wire

// File: rtl/bkb_top.sv
// Purpose: channel B data and bus-cycle break comparator
// Assumes: bus cycle attributes come from logic on the core clock
// Notes: register port answers reads one cycle after the strobe
// Summary of operation
// RULE1 - a 32-bit read/write break data value register resets to zero.
// RULE2 - a 32-bit read/write break data mask register resets to zero so all bits compare.
// RULE3 - each data bit is compared when its mask bit is 0 and ignored when it is 1.
// RULE4 - software picks an operand size whenever the data value is part of the condition.
// RULE5 - for byte compares software writes the same byte to bits 15:8 and 7:0 of the value.
// RULE6 - a 16-bit bus-cycle selection register resets to zero.
// RULE7 - bits 15:8 of the bus-cycle selection register always read as zero.
// RULE8 - source field 00 is off, any code with bit 6 set means CPU, 10 means DMA.
// RULE9 - access field 00 off, 01 fetch, 10 data access, 11 either.
// RULE10 - direction field 00 off, 01 read, 10 write, 11 either.
// RULE11 - size field 00 off, 01 byte, 10 word, 11 longword.
// RULE12 - the data compare joins the condition only while the data enable bit is set.
// RULE13 - a match on a CPU or DMA cycle sets a sticky flag cleared by writing 0 to it.
// RULE14 - a match needs every enabled comparison to hold in the same cycle.
`timescale 1ns/1ps
`default_nettype none
module bkb_top #(
	parameter int DATA_W = 32,
	parameter int ADDR_W = 8,
	parameter int COUNT_W = 16
) (
	// clock and reset
	input wire logic core_clk_in,
	input wire logic reset_in,
	// register port
	input wire logic [ADDR_W-1:0] reg_addr_in,
	input wire logic [DATA_W-1:0] reg_wdata_in,
	input wire logic reg_wr_in,
	input wire logic reg_rd_in,
	output logic [DATA_W-1:0] reg_rdata_out,
	// internal bus cycle under watch
	input wire logic bus_valid_in,
	input wire logic bus_is_dma_in,
	input wire logic bus_is_fetch_in,
	input wire logic bus_is_write_in,
	input wire logic [1:0] bus_size_in,
	input wire logic [DATA_W-1:0] bus_data_in,
	// match reporting
	output logic chan_b_match_out,
	output logic cpu_match_flag_b_out,
	output logic dma_match_flag_b_out
);
	// ==========================================================
	// state
	typedef struct packed {
		logic [DATA_W-1:0] value;
		logic [DATA_W-1:0] mask;
		logic [bkb_pkg::CYCSEL_USED_W-1:0] cycsel;
		logic data_en;
		logic cpu_flag;
		logic dma_flag;
		logic [DATA_W-1:0] capture;
		logic [COUNT_W-1:0] count;
		logic [DATA_W-1:0] rdata;
		logic match;
	} bkb_state_s;

	bkb_state_s st_r;
	bkb_state_s st_nxt;

	// ==========================================================
	// comparators
	logic data_hit;
	logic cycle_hit;
	logic cond_hit;
	logic wr_value;
	logic wr_mask;
	logic wr_cycsel;
	logic wr_ctrl;
	logic wr_count;
	logic [DATA_W-1:0] ctrl_view;
	logic [DATA_W-1:0] cycsel_view;

	bkb_data_cmp #(
		.WIDTH(DATA_W)
	) u_data (
		.data_in(bus_data_in),
		.value_in(st_r.value),
		.mask_in(st_r.mask),
		.hit_out(data_hit)
	);

	bkb_cycle_cmp u_cycle (
		.src_sel_in(st_r.cycsel[bkb_pkg::SRC_LSB +: 2]),
		.kind_sel_in(st_r.cycsel[bkb_pkg::KIND_LSB +: 2]),
		.dir_sel_in(st_r.cycsel[bkb_pkg::DIR_LSB +: 2]),
		.size_sel_in(st_r.cycsel[bkb_pkg::SIZE_LSB +: 2]),
		.is_dma_in(bus_is_dma_in),
		.is_fetch_in(bus_is_fetch_in),
		.is_write_in(bus_is_write_in),
		.size_in(bus_size_in),
		.hit_out(cycle_hit)
	);

	// ==========================================================
	// condition
	always_comb
	begin
		cond_hit = bus_valid_in && cycle_hit && (!st_r.data_en || data_hit); // RULE12 RULE14
	end

	// ==========================================================
	// write decode
	always_comb
	begin
		wr_value = reg_wr_in && (reg_addr_in == bkb_pkg::OFF_VALUE);
		wr_mask = reg_wr_in && (reg_addr_in == bkb_pkg::OFF_MASK);
		wr_cycsel = reg_wr_in && (reg_addr_in == bkb_pkg::OFF_CYCSEL);
		wr_ctrl = reg_wr_in && (reg_addr_in == bkb_pkg::OFF_CTRL);
		wr_count = reg_wr_in && (reg_addr_in == bkb_pkg::OFF_COUNT);
	end

	// ==========================================================
	// read views
	always_comb
	begin
		ctrl_view = '0;
		ctrl_view[bkb_pkg::CTRL_CPU_FLAG_BIT] = st_r.cpu_flag;
		ctrl_view[bkb_pkg::CTRL_DMA_FLAG_BIT] = st_r.dma_flag;
		ctrl_view[bkb_pkg::CTRL_DATA_EN_BIT] = st_r.data_en;
		cycsel_view = '0;
		cycsel_view[bkb_pkg::CYCSEL_USED_W-1:0] = st_r.cycsel; // RULE7
	end

	// ==========================================================
	// next state
	always_comb
	begin
		st_nxt = st_r;
		// value and mask registers
		if (wr_value)
		begin
			st_nxt.value = reg_wdata_in; // RULE1
		end
		if (wr_mask)
		begin
			st_nxt.mask = reg_wdata_in; // RULE2
		end
		// bus-cycle selector, upper bits not stored
		if (wr_cycsel)
		begin
			st_nxt.cycsel = reg_wdata_in[bkb_pkg::CYCSEL_USED_W-1:0]; // RULE6 RULE7
		end
		// control: enable written freely, flags only cleared by a 0
		if (wr_ctrl)
		begin
			st_nxt.data_en = reg_wdata_in[bkb_pkg::CTRL_DATA_EN_BIT]; // RULE12
			if (!reg_wdata_in[bkb_pkg::CTRL_CPU_FLAG_BIT])
			begin
				st_nxt.cpu_flag = 1'b0; // RULE13
			end
			if (!reg_wdata_in[bkb_pkg::CTRL_DMA_FLAG_BIT])
			begin
				st_nxt.dma_flag = 1'b0; // RULE13
			end
		end
		// match sets win over a clear in the same cycle
		if (cond_hit && !bus_is_dma_in)
		begin
			st_nxt.cpu_flag = 1'b1; // RULE13
		end
		if (cond_hit && bus_is_dma_in)
		begin
			st_nxt.dma_flag = 1'b1; // RULE13
		end
		// capture of the last matching data word
		if (cond_hit)
		begin
			st_nxt.capture = bus_data_in;
		end
		// saturating match counter, any write to the count register clears it
		if (wr_count)
		begin
			st_nxt.count = bkb_pkg::RST_COUNT;
		end
		else if (cond_hit && (st_r.count != bkb_pkg::COUNT_MAX))
		begin
			st_nxt.count = st_r.count + 16'h0001;
		end
		// one-cycle match pulse
		st_nxt.match = cond_hit; // RULE14
		// read data stands for one cycle only
		st_nxt.rdata = bkb_pkg::RD_IDLE;
		if (reg_rd_in)
		begin
			unique case (reg_addr_in)
				bkb_pkg::OFF_VALUE:
				begin
					st_nxt.rdata = st_r.value; // RULE1
				end
				bkb_pkg::OFF_MASK:
				begin
					st_nxt.rdata = st_r.mask; // RULE2
				end
				bkb_pkg::OFF_CYCSEL:
				begin
					st_nxt.rdata = cycsel_view; // RULE7
				end
				bkb_pkg::OFF_CTRL:
				begin
					st_nxt.rdata = ctrl_view;
				end
				bkb_pkg::OFF_CAPTURE:
				begin
					st_nxt.rdata = st_r.capture;
				end
				bkb_pkg::OFF_COUNT:
				begin
					st_nxt.rdata = {16'h0000, st_r.count};
				end
				default:
				begin
					st_nxt.rdata = bkb_pkg::RD_IDLE;
				end
			endcase
		end
	end

	// ==========================================================
	// state register
	always_ff @(posedge core_clk_in or posedge reset_in)
	begin
		if (reset_in)
		begin
			st_r.value <= bkb_pkg::RST_VALUE; // RULE1
			st_r.mask <= bkb_pkg::RST_MASK; // RULE2
			st_r.cycsel <= bkb_pkg::RST_CYCSEL[bkb_pkg::CYCSEL_USED_W-1:0]; // RULE6
			st_r.data_en <= 1'b0; // RULE12
			st_r.cpu_flag <= 1'b0;
			st_r.dma_flag <= 1'b0;
			st_r.capture <= bkb_pkg::RST_CAPTURE;
			st_r.count <= bkb_pkg::RST_COUNT;
			st_r.rdata <= bkb_pkg::RD_IDLE;
			st_r.match <= 1'b0;
		end
		else
		begin
			st_r <= st_nxt;
		end
	end

	// ==========================================================
	// outputs
	assign reg_rdata_out = st_r.rdata;
	assign chan_b_match_out = st_r.match;
	assign cpu_match_flag_b_out = st_r.cpu_flag;
	assign dma_match_flag_b_out = st_r.dma_flag;
endmodule
`default_nettype wire

// File: dv/bkb_top_props.sv
// Purpose: port assertions for bkb_top
// Assumes: one clock, async high reset
// Notes: bound below the module
`timescale 1ns/1ps
`default_nettype none
module bkb_top_chk #(
	parameter int DATA_W = 32,
	parameter int ADDR_W = 8,
	parameter int COUNT_W = 16
) (
	// clock and reset
	input wire logic core_clk_in,
	input wire logic reset_in,
	// register port
	input wire logic [ADDR_W-1:0] reg_addr_in,
	input wire logic [DATA_W-1:0] reg_wdata_in,
	input wire logic reg_wr_in,
	input wire logic reg_rd_in,
	input wire logic [DATA_W-1:0] reg_rdata_out,
	// bus cycle
	input wire logic bus_valid_in,
	input wire logic bus_is_dma_in,
	input wire logic bus_is_fetch_in,
	input wire logic bus_is_write_in,
	input wire logic [1:0] bus_size_in,
	input wire logic [DATA_W-1:0] bus_data_in,
	// results
	input wire logic chan_b_match_out,
	input wire logic cpu_match_flag_b_out,
	input wire logic dma_match_flag_b_out
);
	// ====
	// properties
	default clocking @(posedge core_clk_in); endclocking
	default disable iff (reset_in);
	logic ctrl_wr;
	assign ctrl_wr = reg_wr_in && reg_addr_in == bkb_pkg::OFF_CTRL;
	chk_match_cause: assert property (chan_b_match_out |-> $past(bus_valid_in))
		else $error("match without bus cycle");
	chk_idle_quiet: assert property (!bus_valid_in |=> !chan_b_match_out)
		else $error("match on idle bus");
	chk_cpu_set: assert property (bus_valid_in && !bus_is_dma_in ##1 chan_b_match_out
		|-> cpu_match_flag_b_out) else $error("cpu flag not set");
	chk_dma_set: assert property (bus_valid_in && bus_is_dma_in ##1 chan_b_match_out
		|-> dma_match_flag_b_out) else $error("dma flag not set");
	chk_cpu_hold: assert property (cpu_match_flag_b_out && !ctrl_wr
		|=> cpu_match_flag_b_out) else $error("cpu flag dropped");
	chk_dma_hold: assert property (dma_match_flag_b_out && !ctrl_wr
		|=> dma_match_flag_b_out) else $error("dma flag dropped");
	chk_flag_cause: assert property ($rose(cpu_match_flag_b_out) |-> chan_b_match_out
		&& !$past(bus_is_dma_in)) else $error("cpu flag without cpu match");
	chk_flag_clear: assert property (ctrl_wr && !reg_wdata_in[14] && !bus_valid_in
		|=> !cpu_match_flag_b_out) else $error("cpu flag not cleared");
	chk_rsv_zero: assert property (reg_rd_in && reg_addr_in == bkb_pkg::OFF_CYCSEL
		|=> reg_rdata_out[15:8] == 8'h00) else $error("reserved bits not zero");
	cov_match: cover property (chan_b_match_out);
	cov_dma_flag: cover property ($rose(dma_match_flag_b_out));
	cov_clear: cover property (ctrl_wr && cpu_match_flag_b_out);
endmodule
bind bkb_top bkb_top_chk #(.DATA_W(DATA_W), .ADDR_W(ADDR_W), .COUNT_W(COUNT_W)) u_bkb_top_chk (
	.core_clk_in, .reset_in, .reg_addr_in, .reg_wdata_in, .reg_wr_in, .reg_rd_in,
	.reg_rdata_out, .bus_valid_in, .bus_is_dma_in, .bus_is_fetch_in, .bus_is_write_in,
	.bus_size_in, .bus_data_in, .chan_b_match_out, .cpu_match_flag_b_out, .dma_match_flag_b_out);
`default_nettype wire

// File: dv/bkb_bus_model.sv
// Purpose: cpu and dma bus cycle source
// Assumes: one cycle per call, core clock
// Notes: released data lines are inverted
`timescale 1ns/1ps
`default_nettype none
module bkb_bus_model (
	// clock
	input wire logic clk_in,
	// bus cycle
	output logic valid_out,
	output logic dma_out,
	output logic fetch_out,
	output logic write_out,
	output logic [1:0] size_out,
	output logic [31:0] data_out
);
	// ====
	// cycle driver
	initial
	begin
		valid_out = 1'h0;
		dma_out = 1'h0;
		fetch_out = 1'h0;
		write_out = 1'h0;
		size_out = 2'h0;
		data_out = 32'h0;
	end
	task cyc(input logic d, f, w, input logic [1:0] z, input logic [31:0] v);
		@(posedge clk_in);
		valid_out <= 1'h1;
		dma_out <= d;
		fetch_out <= f;
		write_out <= w;
		size_out <= z;
		data_out <= v;
		@(posedge clk_in);
		valid_out <= 1'h0;
		data_out <= ~v;
	endtask
endmodule
`default_nettype wire

// File: dv/bkb_top_test.sv
// Purpose: self-checking bench for bkb_top
// Assumes: 100 MHz clock, reset for 8 cycles
// Notes: exhaustive cycle selector sweep
`timescale 1ns/1ps
`default_nettype none
module bkb_top_test;
	logic clk, rst, wr, rd, valid, dma, fetch, wrt, hit, fc, fd;
	logic [7:0] addr;
	logic [31:0] wd, rdata, data;
	logic [1:0] size;
	int failures, checked;
	bkb_top u_bkb_top (.core_clk_in(clk), .reset_in(rst), .reg_addr_in(addr),
		.reg_wdata_in(wd), .reg_wr_in(wr), .reg_rd_in(rd), .reg_rdata_out(rdata),
		.bus_valid_in(valid), .bus_is_dma_in(dma), .bus_is_fetch_in(fetch),
		.bus_is_write_in(wrt), .bus_size_in(size), .bus_data_in(data),
		.chan_b_match_out(hit), .cpu_match_flag_b_out(fc), .dma_match_flag_b_out(fd));
	bkb_bus_model u_bkb_bus_model (.clk_in(clk), .valid_out(valid), .dma_out(dma),
		.fetch_out(fetch), .write_out(wrt), .size_out(size), .data_out(data));
	// ====
	// helpers
	initial
	begin
		clk = 1'h0;
		forever #5 clk = ~clk;
	end
	task chk(input logic [31:0] s, e);
		checked++;
		if (s !== e)
		begin
			failures++;
			$display("ERROR %0t saw %h want %h", $time, s, e);
		end
	endtask
	task wreg(input logic [7:0] a, input logic [31:0] v);
		@(posedge clk);
		wr <= 1'h1;
		addr <= a;
		wd <= v;
		@(posedge clk);
		wr <= 1'h0;
	endtask
	task rchk(input logic [7:0] a, input logic [31:0] e);
		@(posedge clk);
		rd <= 1'h1;
		addr <= a;
		@(posedge clk);
		rd <= 1'h0;
		#1 chk(rdata, e);
	endtask
	task bus(input logic d, f, w, input logic [1:0] z, input logic [31:0] v, input logic e);
		u_bkb_bus_model.cyc(d, f, w, z, v);
		#1 chk({31'h0, hit}, {31'h0, e});
	endtask
	function automatic logic exp_hit(logic [7:0] s, logic [4:0] c);
		return (s[7:6] == 2'h0 || (s[6] ? !c[4] : c[4]))
			&& (s[5:4] == 2'h0 || (c[3] ? s[4] : s[5]))
			&& (s[3:2] == 2'h0 || (c[2] ? s[3] : s[2]))
			&& (s[1:0] == 2'h0 || s[1:0] == c[1:0]);
	endfunction
	task tally_and_finish;
		$display("checks %0d errors %0d", checked, failures);
		if (failures == 0 && checked > 0)
			$display("Result: passed");
		else
			$display("Result: failed");
		$finish;
	endtask
	// ====
	// scenarios
	task t_regs;
		rchk(bkb_pkg::OFF_VALUE, 32'h0);
		rchk(bkb_pkg::OFF_MASK, 32'h0);
		rchk(bkb_pkg::OFF_CYCSEL, 32'h0);
		wreg(bkb_pkg::OFF_VALUE, 32'ha5c3_0ff1);
		wreg(bkb_pkg::OFF_MASK, 32'h5a3c_f00e);
		wreg(bkb_pkg::OFF_CYCSEL, 32'hffff_ffff);
		rchk(bkb_pkg::OFF_VALUE, 32'ha5c3_0ff1);
		rchk(bkb_pkg::OFF_MASK, 32'h5a3c_f00e);
		rchk(bkb_pkg::OFF_CYCSEL, 32'h0000_00ff);
		rchk(8'h3c, 32'h0);
		wreg(bkb_pkg::OFF_MASK, 32'h0);
	endtask
	task t_fields;
		for (int s = 0; s < 256; s++)
		begin
			wreg(bkb_pkg::OFF_CYCSEL, {24'h0, s[7:0]});
			for (int c = 0; c < 32; c++)
				bus(c[4], c[3], c[2], c[1:0], 32'h0,
					exp_hit(s[7:0], c[4:0]));
		end
	endtask
	task t_data;
		wreg(bkb_pkg::OFF_CTRL, 32'h0000_0080);
		wreg(bkb_pkg::OFF_CYCSEL, 32'h0000_0001);
		wreg(bkb_pkg::OFF_VALUE, 32'h0000_3c3c);
		wreg(bkb_pkg::OFF_MASK, 32'hffff_0000);
		wreg(bkb_pkg::OFF_COUNT, 32'h0);
		bus(1'h0, 1'h0, 1'h0, 2'h1, 32'h1234_3c3c, 1'h1);
		bus(1'h0, 1'h0, 1'h0, 2'h1, 32'h1234_3c3d, 1'h0);
		wreg(bkb_pkg::OFF_MASK, 32'hffff_0001);
		bus(1'h0, 1'h0, 1'h0, 2'h1, 32'h1234_3c3d, 1'h1);
		bus(1'h0, 1'h0, 1'h0, 2'h2, 32'h1234_3c3c, 1'h0);
		wreg(bkb_pkg::OFF_CTRL, 32'h0);
		bus(1'h0, 1'h0, 1'h0, 2'h1, 32'h0bad_0000, 1'h1);
		rchk(bkb_pkg::OFF_CAPTURE, 32'h0bad_0000);
		rchk(bkb_pkg::OFF_COUNT, 32'h0000_0003);
	endtask
	task t_flags;
		wreg(bkb_pkg::OFF_CTRL, 32'h0);
		#1 chk(fc, 1'h0);
		wreg(bkb_pkg::OFF_CYCSEL, 32'h0000_0040);
		bus(1'h1, 1'h0, 1'h0, 2'h1, 32'h0, 1'h0);
		chk(fd, 1'h0);
		chk(fc, 1'h0);
		bus(1'h0, 1'h0, 1'h0, 2'h1, 32'h0, 1'h1);
		chk(fc, 1'h1);
		wreg(bkb_pkg::OFF_CTRL, 32'h0000_5000);
		#1 chk(fc, 1'h1);
		rchk(bkb_pkg::OFF_CTRL, 32'h0000_4000);
		wreg(bkb_pkg::OFF_CYCSEL, 32'h0000_0080);
		bus(1'h1, 1'h0, 1'h0, 2'h1, 32'h0, 1'h1);
		chk(fd, 1'h1);
		wreg(bkb_pkg::OFF_CTRL, 32'h0000_1000);
		#1 chk(fc, 1'h0);
		chk(fd, 1'h1);
		wreg(bkb_pkg::OFF_CTRL, 32'h0);
		#1 chk(fd, 1'h0);
	endtask
	task t_reset;
		wreg(bkb_pkg::OFF_VALUE, 32'h1357_9bdf);
		wreg(bkb_pkg::OFF_CYCSEL, 32'h0000_0040);
		bus(1'h0, 1'h1, 1'h0, 2'h3, 32'h0, 1'h1);
		chk(fc, 1'h1);
		@(posedge clk);
		rst <= 1'h1;
		repeat (2) @(posedge clk);
		rst <= 1'h0;
		#1 chk(fc, 1'h0);
		rchk(bkb_pkg::OFF_VALUE, 32'h0);
		rchk(bkb_pkg::OFF_MASK, 32'h0);
		rchk(bkb_pkg::OFF_CYCSEL, 32'h0);
	endtask
	// ====
	// main sequence and watchdog
	initial
	begin
		rst = 1'h1;
		wr = 1'h0;
		rd = 1'h0;
		addr = 8'h0;
		wd = 32'h0;
		repeat (8) @(posedge clk);
		rst <= 1'h0;
		t_regs;
		t_fields;
		t_data;
		t_flags;
		t_reset;
		tally_and_finish;
	end
	initial
	begin
		repeat (40000) @(posedge clk);
		failures++;
		tally_and_finish;
	end
endmodule
`default_nettype wire
